// ==== design/sbcm_defs.svh ====
// Constants of the operating-mode sequencer: timing, SPI frame layout, mode codes.
// Assumes a 100 MHz system clock.
`ifndef SBCM_DEFS_SVH
`define SBCM_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SBCM_CLK_MHZ 100
`define SBCM_T_RD_US 10
`define SBCM_T_LW_US 200000

// ----------------------------------------
// SPI frame
// ----------------------------------------
`define SBCM_FRAME_BITS 5'h10
`define SBCM_BIT_WR 15
`define SBCM_ADDR_HI 14
`define SBCM_ADDR_LO 8
`define SBCM_MODE_HI 7
`define SBCM_MODE_LO 6
`define SBCM_MSC_ADDR 7'h01

// ----------------------------------------
// Mode field codes
// ----------------------------------------
`define SBCM_MODE_NORMAL 2'h0
`define SBCM_MODE_SLEEP 2'h1
`define SBCM_MODE_STOP 2'h2
`define SBCM_MODE_SRST 2'h3

// ----------------------------------------
// Synchroniser bit positions
// ----------------------------------------
`define SBCM_SYNC_W 11
`define SBCM_S_SCLK 0
`define SBCM_S_CS 1
`define SBCM_S_MOSI 2
`define SBCM_S_INT 3
`define SBCM_S_TEST 4
`define SBCM_S_WK_LO 5
`define SBCM_S_WK_HI 10

`endif

// ==== design/sbcm_pkg.sv ====
// Types shared by the operating-mode sequencer.
// Assumes nothing beyond a SystemVerilog elaborator.
package sbcm_pkg;

	typedef enum logic [5:0] {
		ST_INIT = 6'h01,
		ST_NORMAL = 6'h02,
		ST_STOP = 6'h04,
		ST_SLEEP = 6'h08,
		ST_RESTART = 6'h10,
		ST_FAILSAFE = 6'h20
	} sbcm_state_t;

endpackage : sbcm_pkg

// ==== design/sbcm_sync.sv ====
// Two-flip-flop synchroniser for a group of asynchronous pins.
// Assumes the pins are quasi-static relative to clk.
`timescale 1ns/1ns
module sbcm_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	logic [W-1:0] meta_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= '0;
			dout <= '0;
		end else begin
			meta_r <= din;
			dout <= meta_r;
		end
	end

endmodule : sbcm_sync

// ==== design/sbcm_mode_fsm.sv ====
// Operating-mode sequencer of a system basis chip with its 16-bit SPI port.
// Assumes a 100 MHz clock, arst_n as power-on reset, failure inputs from same-clock logic.
//
// Overview of operation
// (R1) Exactly six modes: Init, Normal, Stop, Sleep, Restart, Fail-Safe
// (R2) Init at power-up and after soft reset
// (R3) Stop keeps main regulator on
// (R4) Sleep switches main regulator off
// (R5) Wake or failure enters Restart, reset held
// (R6) Restart exits to Normal after reset delay
// (R7) Critical failure enters Fail-Safe, regulator off
// (R8) Fail-Safe held until wake or overtemperature gone
// (R9) Development mode freezes watchdog counter
// (R10) Development mode still reaches all six modes
// (R11) Test pin low in Init selects Development
// (R12) Control and status through 16-bit SPI frames
// (R13) Mode field write selects the operating mode
// (R14) Mode field cleared when passing through Restart
// (R15) Power-on threshold crossing starts in Init
// (R16) Init starts watchdog long open window
// (R17) Interrupt pin level stores failure reaction
// (R18) Test pin level stores Development mode
// (R19) Any SPI command in Init gives Normal
// (R20) Missed trigger in long window enters Restart
// (R21) Wake events in Init are discarded
// (R22) Configuration latched at reset output rising edge
// (R23) Each selectable mode has a distinct code
`timescale 1ns/1ns
`include "sbcm_defs.svh"
module sbcm_mode_fsm #(
	parameter int unsigned LW_CYC = `SBCM_T_LW_US * `SBCM_CLK_MHZ
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	input wire logic int_pin_in,
	output logic int_pd_en,
	input wire logic fail_output3_test_pin,
	input wire logic can_wake,
	input wire logic [1:0] lin_bus_inputs,
	input wire logic [2:0] wake_inputs,
	input wire logic wd_trigger,
	input wire logic wd_fail,
	input wire logic main_regulator_output_uv,
	input wire logic main_regulator_output_ov,
	input wire logic ov_rst_en,
	input wire logic overtemp,
	output logic main_regulator_output,
	output logic reset_output_pin,
	output logic wd_freeze,
	output logic cfgp,
	output logic dev_mode,
	output logic [1:0] mode_field,
	output sbcm_pkg::sbcm_state_t mode_state
);
	localparam int unsigned RD_CYC = `SBCM_T_RD_US * `SBCM_CLK_MHZ;
	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	logic [`SBCM_SYNC_W-1:0] s;
	logic [`SBCM_SYNC_W-1:0] s_d_r;
	sbcm_sync #(.W(`SBCM_SYNC_W)) u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.din({wake_inputs, lin_bus_inputs, can_wake, fail_output3_test_pin, int_pin_in, spi_mosi, spi_cs_n, spi_sclk}),
		.dout(s)
	);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_d_r <= '0;
		end else begin
			s_d_r <= s;
		end
	end
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	logic wake_any;
	assign sclk_rise = s[`SBCM_S_SCLK] & ~s_d_r[`SBCM_S_SCLK];
	assign sclk_fall = ~s[`SBCM_S_SCLK] & s_d_r[`SBCM_S_SCLK];
	assign cs_fall = ~s[`SBCM_S_CS] & s_d_r[`SBCM_S_CS];
	assign cs_rise = s[`SBCM_S_CS] & ~s_d_r[`SBCM_S_CS];
	assign wake_any = |(s[`SBCM_S_WK_HI:`SBCM_S_WK_LO] & ~s_d_r[`SBCM_S_WK_HI:`SBCM_S_WK_LO]);

	// ----------------------------------------
	// SPI slave
	// ----------------------------------------
	sbcm_pkg::sbcm_state_t st_r;
	sbcm_pkg::sbcm_state_t st_nxt;
	logic [15:0] sh_in_r;
	logic [15:0] sh_out_r;
	logic [4:0] bit_cnt_r;
	logic [1:0] mode_field_r;
	logic cfgp_r;
	logic dev_r;
	logic miso_oe_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sh_in_r <= 16'h0000;
			bit_cnt_r <= 5'h00;
		end else if (cs_fall) begin
			bit_cnt_r <= 5'h00;
		end else if (sclk_rise && !s[`SBCM_S_CS]) begin
			sh_in_r <= {sh_in_r[14:0], s[`SBCM_S_MOSI]}; // [R12]
			if (bit_cnt_r != 5'h1f) begin
				bit_cnt_r <= bit_cnt_r + 5'h01;
			end
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sh_out_r <= 16'h0000;
		end else if (cs_fall) begin
			sh_out_r <= {1'h0, cfgp_r, dev_r, 5'h00, mode_field_r, 6'h00};
		end else if (sclk_fall && !s[`SBCM_S_CS]) begin
			sh_out_r <= {sh_out_r[14:0], 1'h0};
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			miso_oe_r <= 1'h0;
		end else begin
			miso_oe_r <= ~s[`SBCM_S_CS];
		end
	end
	assign spi_miso = sh_out_r[15];
	assign spi_miso_oe = miso_oe_r;
	logic frame_end;
	logic mode_wr;
	logic [1:0] mode_code;
	assign frame_end = cs_rise && (bit_cnt_r != 5'h00);
	assign mode_code = sh_in_r[`SBCM_MODE_HI:`SBCM_MODE_LO];
	assign mode_wr = cs_rise && (bit_cnt_r == `SBCM_FRAME_BITS) && sh_in_r[`SBCM_BIT_WR]
		&& (sh_in_r[`SBCM_ADDR_HI:`SBCM_ADDR_LO] == `SBCM_MSC_ADDR);

	// ----------------------------------------
	// Reset delay and reset output
	// ----------------------------------------
	logic ro_r;
	logic [31:0] rd_cnt_r;
	logic rd_run;
	logic rd_exp;
	logic cfg_done_r;
	assign rd_run = ((st_r == sbcm_pkg::ST_RESTART) || ((st_r == sbcm_pkg::ST_INIT) && !ro_r)) && !main_regulator_output_uv;
	assign rd_exp = rd_run && (rd_cnt_r == RD_CYC - 1);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_cnt_r <= '0;
		end else if (!rd_run || rd_exp || (st_nxt != st_r)) begin
			rd_cnt_r <= '0;
		end else begin
			rd_cnt_r <= rd_cnt_r + 32'h0000_0001; // [R6]
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ro_r <= 1'h0; // [R15]
		end else if (st_nxt == sbcm_pkg::ST_RESTART) begin
			ro_r <= 1'h0; // [R5]
		end else if (rd_exp) begin
			ro_r <= 1'h1;
		end
	end
	// Configuration captured once per power-up
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfgp_r <= 1'h0;
			dev_r <= 1'h0;
			cfg_done_r <= 1'h0;
		end else if (rd_exp && !cfg_done_r) begin
			cfgp_r <= s[`SBCM_S_INT]; // [R17] [R22]
			dev_r <= ~s[`SBCM_S_TEST]; // [R11] [R18]
			cfg_done_r <= 1'h1;
		end
	end

	// ----------------------------------------
	// Long open window
	// ----------------------------------------
	logic [31:0] lw_cnt_r;
	logic lw_trig_r;
	logic lw_run;
	logic lw_exp;
	assign lw_run = (st_r == sbcm_pkg::ST_INIT) && ro_r && !lw_trig_r && !dev_r;
	assign lw_exp = lw_run && (lw_cnt_r == LW_CYC - 1);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lw_trig_r <= 1'h0;
		end else if (st_r != sbcm_pkg::ST_INIT) begin
			lw_trig_r <= 1'h0;
		end else if (wd_trigger && ro_r) begin
			lw_trig_r <= 1'h1;
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lw_cnt_r <= '0;
		end else if ((st_r != sbcm_pkg::ST_INIT) || !ro_r) begin
			lw_cnt_r <= '0;
		end else if (lw_run) begin
			lw_cnt_r <= lw_cnt_r + 32'h0000_0001; // [R16] [R9]
		end
	end

	// ----------------------------------------
	// Mode state machine
	// ----------------------------------------
	logic wd_evt;
	logic ov_evt;
	logic fail_rst;
	logic fail_fs;
	logic ot_d_r;
	logic ot_fall;
	assign wd_evt = wd_fail && !dev_r; // [R9]
	assign ov_evt = main_regulator_output_ov && ov_rst_en;
	assign fail_rst = main_regulator_output_uv || ((wd_evt || ov_evt) && cfgp_r); // [R5]
	assign fail_fs = (wd_evt || ov_evt) && !cfgp_r; // [R7]
	assign ot_fall = ot_d_r && !overtemp;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ot_d_r <= 1'h0;
		end else begin
			ot_d_r <= overtemp;
		end
	end
	// Failures take priority over software requests
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			sbcm_pkg::ST_INIT: begin
				if (!ro_r) begin
					st_nxt = sbcm_pkg::ST_INIT;
				end else if (lw_exp || fail_rst) begin
					st_nxt = sbcm_pkg::ST_RESTART; // [R20]
				end else if (fail_fs) begin
					st_nxt = sbcm_pkg::ST_FAILSAFE;
				end else if (frame_end) begin
					st_nxt = sbcm_pkg::ST_NORMAL; // [R19] [R21]
				end
			end
			sbcm_pkg::ST_NORMAL, sbcm_pkg::ST_STOP: begin
				if (fail_rst) begin
					st_nxt = sbcm_pkg::ST_RESTART;
				end else if (fail_fs) begin
					st_nxt = sbcm_pkg::ST_FAILSAFE; // [R7]
				end else if (mode_wr) begin
					case (mode_code) // [R13] [R10]
						`SBCM_MODE_NORMAL: st_nxt = sbcm_pkg::ST_NORMAL;
						`SBCM_MODE_SLEEP: st_nxt = sbcm_pkg::ST_SLEEP;
						`SBCM_MODE_STOP: st_nxt = sbcm_pkg::ST_STOP;
						default: st_nxt = sbcm_pkg::ST_INIT; // [R2]
					endcase
				end
			end
			sbcm_pkg::ST_SLEEP: begin
				if (wake_any) begin
					st_nxt = sbcm_pkg::ST_RESTART; // [R5]
				end
			end
			sbcm_pkg::ST_RESTART: begin
				if (rd_exp) begin
					st_nxt = sbcm_pkg::ST_NORMAL; // [R6]
				end
			end
			sbcm_pkg::ST_FAILSAFE: begin
				if (wake_any || ot_fall) begin
					st_nxt = sbcm_pkg::ST_RESTART; // [R8]
				end
			end
			default: st_nxt = sbcm_pkg::ST_INIT;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= sbcm_pkg::ST_INIT; // [R1] [R2]
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Mode field
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_field_r <= `SBCM_MODE_NORMAL;
		end else if ((st_nxt == sbcm_pkg::ST_RESTART) && (st_r != sbcm_pkg::ST_RESTART)) begin
			mode_field_r <= `SBCM_MODE_NORMAL; // [R14]
		end else if (mode_wr && ((st_r == sbcm_pkg::ST_NORMAL) || (st_r == sbcm_pkg::ST_STOP))) begin
			mode_field_r <= mode_code; // [R23]
		end
	end

	// ----------------------------------------
	// Regulator and outputs
	// ----------------------------------------
	logic reg_en_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_en_r <= 1'h1;
		end else begin
			reg_en_r <= (st_nxt != sbcm_pkg::ST_SLEEP) && (st_nxt != sbcm_pkg::ST_FAILSAFE); // [R3] [R4] [R7]
		end
	end

	assign main_regulator_output = reg_en_r;
	assign reset_output_pin = ro_r;
	assign int_pd_en = ~ro_r;
	assign wd_freeze = dev_r; // [R9]
	assign cfgp = cfgp_r;
	assign dev_mode = dev_r;
	assign mode_field = mode_field_r;
	assign mode_state = st_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	chk_state_onehot: assert property ($onehot(st_r)) // [R1]
		else $error("mode state not one-hot");
	chk_stop_reg_on: assert property (st_r == sbcm_pkg::ST_STOP |-> reg_en_r) // [R3]
		else $error("regulator off in Stop");
	chk_sleep_reg_off: assert property (st_r == sbcm_pkg::ST_SLEEP |-> !reg_en_r) // [R4]
		else $error("regulator on in Sleep");
	chk_fs_reg_off: assert property (st_r == sbcm_pkg::ST_FAILSAFE |-> !reg_en_r) // [R7]
		else $error("regulator on in Fail-Safe");
	chk_restart_reset: assert property (st_r == sbcm_pkg::ST_RESTART |-> !ro_r) // [R5]
		else $error("reset released in Restart");
	chk_sleep_wake: assert property (st_r == sbcm_pkg::ST_SLEEP && wake_any |=> st_r == sbcm_pkg::ST_RESTART) // [R5]
		else $error("wake in Sleep missed");
	chk_restart_exit: assert property ($past(st_r) == sbcm_pkg::ST_RESTART && st_r == sbcm_pkg::ST_NORMAL
		|-> ro_r && $past(rd_cnt_r) == RD_CYC - 1 && !$past(main_regulator_output_uv)) // [R6]
		else $error("Restart left early");
	chk_fs_hold: assert property (st_r == sbcm_pkg::ST_FAILSAFE && !wake_any && !ot_fall
		|=> st_r == sbcm_pkg::ST_FAILSAFE) // [R8]
		else $error("Fail-Safe left without cause");
	chk_dev_freeze: assert property (dev_r && st_r == sbcm_pkg::ST_INIT && ro_r |=> $stable(lw_cnt_r)) // [R9]
		else $error("window counter runs in Development");
	chk_mode_clear: assert property ($rose(st_r == sbcm_pkg::ST_RESTART) |-> mode_field_r == `SBCM_MODE_NORMAL) // [R14]
		else $error("mode field not cleared");
	chk_init_spi: assert property (st_r == sbcm_pkg::ST_INIT && ro_r && frame_end && !lw_exp && !fail_rst
		&& !fail_fs |=> st_r == sbcm_pkg::ST_NORMAL) // [R19]
		else $error("SPI command in Init ignored");
	chk_init_wake: assert property (st_r == sbcm_pkg::ST_INIT && wake_any && !frame_end && !lw_exp && !fail_rst
		&& !fail_fs |=> st_r == sbcm_pkg::ST_INIT) // [R21]
		else $error("wake acted on in Init");
	chk_lw_expiry: assert property (lw_exp && !dev_r |=> st_r == sbcm_pkg::ST_RESTART ##1 !ro_r) // [R20]
		else $error("window expiry missed");
	chk_cfg_latch: assert property ($rose(ro_r) && !$past(cfg_done_r) |-> cfgp_r == $past(s[`SBCM_S_INT])
		&& dev_r == !$past(s[`SBCM_S_TEST])) // [R22]
		else $error("configuration not latched");

	cov_init_normal: cover property (st_r == sbcm_pkg::ST_INIT ##1 st_r == sbcm_pkg::ST_NORMAL);
	cov_sleep_restart: cover property (st_r == sbcm_pkg::ST_SLEEP ##1 st_r == sbcm_pkg::ST_RESTART);
	cov_failsafe: cover property (st_r == sbcm_pkg::ST_FAILSAFE ##1 st_r == sbcm_pkg::ST_RESTART);
	cov_dev_stop: cover property (dev_r && st_r == sbcm_pkg::ST_STOP);

endmodule : sbcm_mode_fsm

// ==== bench/sbcm_spi_host.sv ====
// Microcontroller model driving the 16-bit SPI control port of the mode sequencer.
// Assumes the bench calls xfer from one process; all pins move just after a rising clk edge.
`timescale 1ns/1ns
module sbcm_spi_host (
	input wire logic clk,
	input wire logic miso,
	input wire logic miso_oe,
	output logic sclk,
	output logic cs_n,
	output logic mosi
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// ----------------------------------------
	// Frame transfer, MSB first, sclk still between frames
	// ----------------------------------------
	task automatic xfer(input logic [15:0] tx, input int half, output logic [15:0] rx);
		@(posedge clk);
		cs_n <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi <= tx[i];
			repeat (half) @(posedge clk);
			@(negedge clk);
			rx[i] = miso_oe ? miso : 1'bx;
			@(posedge clk);
			sclk <= 1'b1;
			repeat (half) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (half) @(posedge clk);
		cs_n <= 1'b1;
		mosi <= ~tx[0];
		repeat (6) @(posedge clk);
	endtask : xfer
endmodule : sbcm_spi_host

// ==== bench/tb_top.sv ====
// Self-checking bench of the operating-mode sequencer.
// Assumes the design package and header are compiled first.
`timescale 1ns/1ns
module tb_top;
	logic clk, arst_n, ext_pu, test_pin, wd_fail, main_regulator_output_uv, main_regulator_output_ov, reg_on, rst_out, ot, wd_trig;
	logic sclk, cs_n, mosi, miso, miso_oe, int_pd_en, wd_freeze, cfgp, dev_mode;
	logic [5:0] wk;
	logic [1:0] mode_field;
	logic [15:0] rx;
	sbcm_pkg::sbcm_state_t mode_state;
	int bad_count, total_checks;

	sbcm_mode_fsm #(.LW_CYC(300)) sbcm_mode_fsm_inst (.clk(clk), .arst_n(arst_n), .spi_sclk(sclk),
		.spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe), .int_pin_in(ext_pu),
		.int_pd_en(int_pd_en), .fail_output3_test_pin(test_pin), .can_wake(wk[0]), .lin_bus_inputs(wk[2:1]),
		.wake_inputs(wk[5:3]), .wd_trigger(wd_trig), .wd_fail(wd_fail), .main_regulator_output_uv(main_regulator_output_uv), .main_regulator_output_ov(main_regulator_output_ov),
		.ov_rst_en(1'b1), .overtemp(ot), .main_regulator_output(reg_on), .reset_output_pin(rst_out),
		.wd_freeze(wd_freeze), .cfgp(cfgp), .dev_mode(dev_mode), .mode_field(mode_field),
		.mode_state(mode_state));
	sbcm_spi_host sbcm_spi_host_inst (.clk(clk), .miso(miso), .miso_oe(miso_oe), .sclk(sclk), .cs_n(cs_n),
		.mosi(mosi));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------
	// Compare, wait and stimulus tasks
	// ----------------------------------------
	task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_v

	task automatic chk_st(input sbcm_pkg::sbcm_state_t got, input sbcm_pkg::sbcm_state_t exp);
		chk_v(16'(got), 16'(exp));
	endtask : chk_st

	task automatic wait_st(input sbcm_pkg::sbcm_state_t exp, input int n);
		int k;
		k = 0;
		while (mode_state !== exp && k < n) begin
			@(negedge clk);
			k++;
		end
		chk_st(mode_state, exp);
	endtask : wait_st

	task automatic wait_rel();
		int k;
		k = 0;
		while (rst_out !== 1'b1 && k < 1200) begin
			@(negedge clk);
			k++;
		end
	endtask : wait_rel

	task automatic pulse_wk(input int b);
		@(posedge clk);
		wk <= 6'h01 << b;
		repeat (4) @(posedge clk);
		wk <= 6'h00;
	endtask : pulse_wk

	task automatic do_reset(input logic pu, input logic tp);
		@(posedge clk);
		arst_n <= 1'b0;
		ext_pu <= pu;
		test_pin <= tp;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
	endtask : do_reset

	task automatic test_done();
		if (bad_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		arst_n = 1'b0;
		ext_pu = 1'b1;
		test_pin = 1'b1;
		wd_fail = 1'b0;
		ot = 1'b0;
		wd_trig = 1'b0;
		main_regulator_output_uv = 1'b0;
		main_regulator_output_ov = 1'b0;
		wk = 6'h00;
		bad_count = 0;
		total_checks = 0;
		do_reset(1'b1, 1'b1);
		chk_st(mode_state, sbcm_pkg::ST_INIT);
		chk_v(16'({reg_on, rst_out, int_pd_en}), 16'h0005);
		wait_rel();
		chk_v(16'({rst_out, cfgp, dev_mode, wd_freeze}), 16'h000C);
		pulse_wk(3);
		repeat (10) @(negedge clk);
		chk_st(mode_state, sbcm_pkg::ST_INIT);
		wait_st(sbcm_pkg::ST_RESTART, 400);
		wait_st(sbcm_pkg::ST_NORMAL, 1100);
		sbcm_spi_host_inst.xfer(16'h81C0, 4, rx);
		wait_st(sbcm_pkg::ST_INIT, 8);
		@(posedge clk);
		wd_trig <= 1'b1;
		@(posedge clk);
		wd_trig <= 1'b0;
		repeat (400) @(negedge clk);
		chk_st(mode_state, sbcm_pkg::ST_INIT);
		chk_v(16'(rst_out), 16'h0001);
		sbcm_spi_host_inst.xfer(16'h0000, 4, rx);
		wait_st(sbcm_pkg::ST_NORMAL, 8);
		sbcm_spi_host_inst.xfer(16'h8180, 10, rx);
		chk_v(rx, 16'h40C0);
		wait_st(sbcm_pkg::ST_STOP, 8);
		chk_v(16'({mode_field, reg_on}), 16'h0005);
		for (int b = 0; b < 6; b++) begin
			sbcm_spi_host_inst.xfer(16'h8140, 4, rx);
			wait_st(sbcm_pkg::ST_SLEEP, 8);
			chk_v(16'({mode_field, reg_on}), 16'h0002);
			pulse_wk(b);
			wait_st(sbcm_pkg::ST_RESTART, 8);
			chk_v(16'({mode_field, reg_on, rst_out}), 16'h0002);
			wait_st(sbcm_pkg::ST_NORMAL, 1100);
		end
		@(posedge clk);
		wd_fail <= 1'b1;
		@(posedge clk);
		wd_fail <= 1'b0;
		wait_st(sbcm_pkg::ST_RESTART, 8);
		wait_st(sbcm_pkg::ST_NORMAL, 1100);
		@(posedge clk);
		main_regulator_output_uv <= 1'b1;
		wait_st(sbcm_pkg::ST_RESTART, 8);
		repeat (1500) @(negedge clk);
		chk_st(mode_state, sbcm_pkg::ST_RESTART);
		@(posedge clk);
		main_regulator_output_uv <= 1'b0;
		wait_st(sbcm_pkg::ST_NORMAL, 1100);
		do_reset(1'b0, 1'b0);
		wait_rel();
		chk_v(16'({cfgp, dev_mode, wd_freeze}), 16'h0003);
		sbcm_spi_host_inst.xfer(16'h8100, 4, rx);
		wait_st(sbcm_pkg::ST_NORMAL, 8);
		@(posedge clk);
		wd_fail <= 1'b1;
		@(posedge clk);
		wd_fail <= 1'b0;
		repeat (10) @(negedge clk);
		chk_st(mode_state, sbcm_pkg::ST_NORMAL);
		chk_v(16'(rst_out), 16'h0001);
		sbcm_spi_host_inst.xfer(16'h8140, 10, rx);
		chk_v(rx, 16'h2000);
		wait_st(sbcm_pkg::ST_SLEEP, 8);
		pulse_wk(1);
		wait_st(sbcm_pkg::ST_RESTART, 8);
		wait_st(sbcm_pkg::ST_NORMAL, 1100);
		@(posedge clk);
		main_regulator_output_ov <= 1'b1;
		wait_st(sbcm_pkg::ST_FAILSAFE, 8);
		chk_v(16'(reg_on), 16'h0000);
		@(posedge clk);
		main_regulator_output_ov <= 1'b0;
		repeat (20) @(negedge clk);
		chk_st(mode_state, sbcm_pkg::ST_FAILSAFE);
		pulse_wk(5);
		wait_st(sbcm_pkg::ST_RESTART, 8);
		wait_st(sbcm_pkg::ST_NORMAL, 1100);
		@(posedge clk);
		ot <= 1'b1;
		main_regulator_output_ov <= 1'b1;
		wait_st(sbcm_pkg::ST_FAILSAFE, 8);
		@(posedge clk);
		main_regulator_output_ov <= 1'b0;
		repeat (5) @(negedge clk);
		chk_st(mode_state, sbcm_pkg::ST_FAILSAFE);
		@(posedge clk);
		ot <= 1'b0;
		wait_st(sbcm_pkg::ST_RESTART, 4);
		wait_st(sbcm_pkg::ST_NORMAL, 1100);
		test_done();
	end

	initial begin
		#600000;
		bad_count++;
		test_done();
	end
endmodule : tb_top
